// file: verilog/das_seq_ctrl.sv
// Purpose: Instruction sequencer, watchdog compare, result FIFO and status for the converter.
// Assumes: Analog converter outside; it answers each start with one CONV_DONE pulse.
// Notes: APB slave, one wait state on every access.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "das_seq_regs.svh"

module das_seq_ctrl (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire das_seq_pkg::apb_req_t APB_REQ,
  output das_seq_pkg::apb_rsp_t APB_RSP,
  input wire logic CONV_DONE,
  input wire logic [15:0] CONV_RESULT,
  input wire logic CAL_DONE,
  output das_seq_pkg::conv_req_t CONV_REQ,
  output logic CAL_START,
  output logic CAL_FULL,
  output logic STANDBY,
  output logic INT_OUT
);
  import das_seq_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic run_q, run_d, stby_q, stby_d, cstop_q, cstop_d;
  logic [1:0] ptr_q, ptr_d;
  logic [16:0] inten_q, inten_d;
  logic [15:0] timer_q, timer_d, dly_q, dly_d;
  logic [7:0] stat_q, stat_d, stat_set;
  logic [15:0] lstat_q, lstat_d, lstat_set;
  logic [15:0] ins_q [0:7];
  logic [15:0] ins_d [0:7];
  logic [15:0] lim1_q [0:7];
  logic [15:0] lim1_d [0:7];
  logic [15:0] lim2_q [0:7];
  logic [15:0] lim2_d [0:7];
  logic [15:0] fifo_q [0:31];
  logic [15:0] fifo_d [0:31];
  logic [4:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [5:0] cnt_q, cnt_d;
  seq_state_t state_q, state_d;
  logic [2:0] idx_q, idx_d;
  logic res_pend_q, res_pend_d, cal_pend_q, cal_pend_d;
  logic [15:0] res_q, res_d;
  apb_rsp_t rsp_q, rsp_d;
  conv_req_t conv_q, conv_d;
  logic cal_start_q, cal_start_d, cal_full_q, cal_full_d, irq_q, irq_d;

  // Strobes; the assertions watch fifo_push, fifo_pop, dev_rst, cfg_wr and stat_rd
  logic acc, done, hit, fifo_push, fifo_pop, dev_rst, cfg_wr, stat_rd, lstat_rd;
  logic [31:0] rd_data;
  logic [15:0] cur_ins;
  logic f1, f2;

  // Sample beyond one limit; bit 9 picks high or low sense
  function automatic logic out_of_limit(input logic [15:0] smp, input logic [15:0] lim);
    logic signed [15:0] s;
    logic signed [15:0] l;
    s = smp;
    l = {{7{lim[`LIM_VAL_HI]}}, lim[`LIM_VAL_HI:0]};
    out_of_limit = lim[`LIM_HIGH] ? (s > l) : (s < l);
  endfunction : out_of_limit

  // Pointer step, wraps 31 to 0 by width
  function automatic logic [4:0] ptr_next(input logic [4:0] p);
    ptr_next = p + 5'h01;
  endfunction : ptr_next

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    run_d = run_q;
    stby_d = stby_q;
    cstop_d = cstop_q;
    ptr_d = ptr_q;
    inten_d = inten_q;
    timer_d = timer_q;
    dly_d = dly_q;
    ins_d = ins_q;
    lim1_d = lim1_q;
    lim2_d = lim2_q;
    fifo_d = fifo_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    state_d = state_q;
    idx_d = idx_q;
    res_d = res_q;
    res_pend_d = res_pend_q;
    cal_pend_d = cal_pend_q;
    cal_full_d = cal_full_q;
    cal_start_d = 1'b0;
    conv_d = conv_q;
    conv_d.start = 1'b0;
    rsp_d = rsp_q;
    rsp_d.pready = 1'b0;
    rsp_d.pslverr = 1'b0;
    stat_set = 8'h00;
    lstat_set = 16'h0000;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    dev_rst = 1'b0;
    cfg_wr = 1'b0;
    stat_rd = 1'b0;
    lstat_rd = 1'b0;
    hit = 1'b1;
    rd_data = 32'h00000000;
    cur_ins = ins_q[idx_q];
    f1 = out_of_limit(res_q, lim1_q[idx_q]);
    f2 = out_of_limit(res_q, lim2_q[idx_q]);

    // Converter answers are caught even while frozen, so none is lost
    if (CONV_DONE) begin
      res_pend_d = 1'b1;
      res_d = CONV_RESULT;
    end
    if (CAL_DONE) begin
      cal_pend_d = 1'b1;
    end

    // Read mux, decoded in the access cycle
    if (APB_REQ.paddr == `CFG_ADDR) begin
      rd_data = {24'h000000, cstop_q, ptr_q, 2'b00, stby_q, 1'b0, run_q};
    end else if (APB_REQ.paddr == `INTEN_ADDR) begin
      rd_data = {15'h0000, inten_q};
    end else if (APB_REQ.paddr == `INTST_ADDR) begin
      rd_data = {24'h000000, stat_q};
    end else if (APB_REQ.paddr == `TIMER_ADDR) begin
      rd_data = {16'h0000, timer_q};
    end else if (APB_REQ.paddr == `FIFO_ADDR) begin
      rd_data = (cnt_q != 6'h00) ? {16'h0000, fifo_q[rptr_q]} : 32'h00000000;
    end else if (APB_REQ.paddr == `LIMST_ADDR) begin
      rd_data = {16'h0000, lstat_q};
    end else if (APB_REQ.paddr[7:5] == `RAM_BASE >> 5 && APB_REQ.paddr[1:0] == 2'b00) begin
      if (ptr_q == 2'b00) begin
        rd_data = {16'h0000, ins_q[APB_REQ.paddr[4:2]]};
      end else if (ptr_q == 2'b01) begin
        rd_data = {16'h0000, lim1_q[APB_REQ.paddr[4:2]]};
      end else if (ptr_q == 2'b10) begin
        rd_data = {16'h0000, lim2_q[APB_REQ.paddr[4:2]]};
      end
    end else begin
      hit = 1'b0;
    end

    // Bus: answer one cycle after the access phase opens
    acc = APB_REQ.psel && APB_REQ.penable && !rsp_q.pready;
    done = APB_REQ.psel && APB_REQ.penable && rsp_q.pready;
    if (acc) begin
      rsp_d.pready = 1'b1;
      rsp_d.pslverr = !hit;
      rsp_d.prdata = APB_REQ.pwrite ? 32'h00000000 : rd_data;
    end

    // Read side effects at the completing edge
    if (done && !APB_REQ.pwrite) begin
      if (APB_REQ.paddr == `FIFO_ADDR && cnt_q != 6'h00) begin
        fifo_pop = 1'b1;
      end
      stat_rd = (APB_REQ.paddr == `INTST_ADDR);
      lstat_rd = (APB_REQ.paddr == `LIMST_ADDR);
    end

    // Writes take effect at the completing edge
    if (done && APB_REQ.pwrite && hit) begin
      if (APB_REQ.paddr == `CFG_ADDR) begin
        cfg_wr = 1'b1;
        run_d = APB_REQ.pwdata[`CFG_START];
        stby_d = APB_REQ.pwdata[`CFG_STBY];
        cstop_d = APB_REQ.pwdata[`CFG_CNTSTOP];
        ptr_d = APB_REQ.pwdata[`CFG_PTR_HI:`CFG_PTR_LO];
        dev_rst = APB_REQ.pwdata[`CFG_RESET];
        if (APB_REQ.pwdata[`CFG_STBY] && !stby_q) begin
          stat_set[`ST_STBY] = 1'b1;
        end
        if ((APB_REQ.pwdata[`CFG_CALFULL] || APB_REQ.pwdata[`CFG_CALOFS]) && state_q == S_IDLE) begin
          cal_start_d = 1'b1;
          cal_full_d = APB_REQ.pwdata[`CFG_CALFULL];
          cal_pend_d = 1'b0;
          state_d = S_CAL;
        end
      end else if (APB_REQ.paddr == `INTEN_ADDR) begin
        inten_d = APB_REQ.pwdata[16:0];
      end else if (APB_REQ.paddr == `TIMER_ADDR) begin
        timer_d = APB_REQ.pwdata[15:0];
      end else if (APB_REQ.paddr[7:5] == `RAM_BASE >> 5) begin
        if (ptr_q == 2'b00) begin
          ins_d[APB_REQ.paddr[4:2]] = APB_REQ.pwdata[15:0];
        end else if (ptr_q == 2'b01) begin
          lim1_d[APB_REQ.paddr[4:2]] = APB_REQ.pwdata[15:0];
        end else if (ptr_q == 2'b10) begin
          lim2_d[APB_REQ.paddr[4:2]] = APB_REQ.pwdata[15:0];
        end
      end
    end

    // Sequencer; frozen while selected or in standby
    if (!APB_REQ.psel && !stby_q) begin
      case (state_q)
        S_IDLE: begin
          if (run_q && cnt_q != `FIFO_DEPTH) begin
            state_d = S_PREP;
          end
        end
        S_PREP: begin
          if (!run_q) begin
            state_d = S_IDLE;
          end else begin
            if (idx_q == inten_q[`IE_INSTR_HI:`IE_INSTR_LO]) begin
              stat_set[`ST_INSTR] = 1'b1;
            end
            if (cur_ins[`INS_DELAY] && timer_q != 16'h0000) begin
              dly_d = timer_q;
              state_d = S_DELAY;
            end else begin
              conv_d = '{start: 1'b1, mode: cur_ins[`INS_MODE_HI:`INS_MODE_LO],
                         chan: cur_ins[`INS_CHAN_HI:`INS_CHAN_LO]};
              res_pend_d = 1'b0;
              state_d = S_CONV;
            end
          end
        end
        S_DELAY: begin
          dly_d = dly_q - 16'h0001;
          if (dly_q == 16'h0001) begin
            conv_d = '{start: 1'b1, mode: cur_ins[`INS_MODE_HI:`INS_MODE_LO],
                       chan: cur_ins[`INS_CHAN_HI:`INS_CHAN_LO]};
            res_pend_d = 1'b0;
            state_d = S_CONV;
          end
        end
        S_CONV: begin
          if (res_pend_q) begin
            res_pend_d = 1'b0;
            if (cur_ins[`INS_MODE_HI:`INS_MODE_LO] == M_WATCH) begin
              // Compare only; nothing reaches the FIFO
              lstat_set[idx_q] = f1;
              lstat_set[{1'b1, idx_q}] = f2;
              stat_set[`ST_LIMIT] = f1 || f2;
            end else if (cnt_q != `FIFO_DEPTH) begin
              fifo_push = 1'b1;
              if (cnt_q + 6'h01 == inten_q[`IE_COUNT_HI:`IE_COUNT_LO]) begin
                stat_set[`ST_DRDY] = 1'b1;
                if (cstop_q) begin
                  run_d = 1'b0;
                end
              end
              if (cnt_q + 6'h01 == `FIFO_DEPTH) begin
                stat_set[`ST_FULL] = 1'b1;
                run_d = 1'b0;
              end
            end
            // Last instruction either pauses or loops to zero
            if (cur_ins[`INS_PAUSE]) begin
              run_d = 1'b0;
              idx_d = 3'h0;
              stat_set[`ST_PAUSE] = 1'b1;
            end else if (cur_ins[`INS_LOOP] || idx_q == `LAST_INSTR) begin
              idx_d = 3'h0;
              stat_set[`ST_CYCLE] = 1'b1;
            end else begin
              idx_d = idx_q + 3'h1;
            end
            state_d = S_IDLE;
          end
        end
        S_CAL: begin
          if (cal_pend_q) begin
            cal_pend_d = 1'b0;
            stat_set[`ST_CAL] = 1'b1;
            state_d = S_IDLE;
          end
        end
        default: begin
          state_d = S_IDLE;
        end
      endcase
    end

    // FIFO pointers move only on their own side
    if (fifo_push) begin
      fifo_d[wptr_q] = res_q;
      wptr_d = ptr_next(wptr_q);
    end
    if (fifo_pop) begin
      rptr_d = ptr_next(rptr_q);
    end
    cnt_d = cnt_q + {5'h00, fifo_push} - {5'h00, fifo_pop};

    // Clear only bits the host saw; a new event wins
    stat_d = (stat_rd ? (stat_q & ~rsp_q.prdata[7:0]) : stat_q) | stat_set;
    lstat_d = (lstat_rd ? (lstat_q & ~rsp_q.prdata[15:0]) : lstat_q) | lstat_set;

    // Device reset clears pointers, flags and sequencing
    if (dev_rst) begin
      run_d = 1'b0;
      wptr_d = 5'h00;
      rptr_d = 5'h00;
      cnt_d = 6'h00;
      idx_d = 3'h0;
      state_d = S_IDLE;
      res_pend_d = 1'b0;
      cal_pend_d = 1'b0;
      cal_start_d = 1'b0;
      stat_d = 8'h00;
      lstat_d = 16'h0000;
    end

    irq_d = |(stat_d & inten_d[7:0]);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      run_q <= 1'b0;
      stby_q <= 1'b0;
      cstop_q <= 1'b0;
      ptr_q <= 2'b00;
      inten_q <= `INTEN_RST;
      timer_q <= `TIMER_RST;
      dly_q <= 16'h0000;
      stat_q <= 8'h00;
      lstat_q <= 16'h0000;
      for (int i = 0; i < 8; i++) begin
        ins_q[i] <= 16'h0000;
        lim1_q[i] <= 16'h0000;
        lim2_q[i] <= 16'h0000;
      end
      for (int j = 0; j < 32; j++) begin
        fifo_q[j] <= 16'h0000;
      end
      wptr_q <= 5'h00;
      rptr_q <= 5'h00;
      cnt_q <= 6'h00;
      state_q <= S_IDLE;
      idx_q <= 3'h0;
      res_q <= 16'h0000;
      res_pend_q <= 1'b0;
      cal_pend_q <= 1'b0;
      rsp_q <= '0;
      conv_q <= '0;
      cal_start_q <= 1'b0;
      cal_full_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      run_q <= run_d;
      stby_q <= stby_d;
      cstop_q <= cstop_d;
      ptr_q <= ptr_d;
      inten_q <= inten_d;
      timer_q <= timer_d;
      dly_q <= dly_d;
      stat_q <= stat_d;
      lstat_q <= lstat_d;
      ins_q <= ins_d;
      lim1_q <= lim1_d;
      lim2_q <= lim2_d;
      fifo_q <= fifo_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      state_q <= state_d;
      idx_q <= idx_d;
      res_q <= res_d;
      res_pend_q <= res_pend_d;
      cal_pend_q <= cal_pend_d;
      rsp_q <= rsp_d;
      conv_q <= conv_d;
      cal_start_q <= cal_start_d;
      cal_full_q <= cal_full_d;
      irq_q <= irq_d;
    end
  end

  // Outputs straight from flops
  assign APB_RSP = rsp_q;
  assign CONV_REQ = conv_q;
  assign CAL_START = cal_start_q;
  assign CAL_FULL = cal_full_q;
  assign STANDBY = stby_q;
  assign INT_OUT = irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_follows_mask: assert property (@(posedge CLK) disable iff (SYS_RST)
    ##1 (INT_OUT == |(stat_q & inten_q[7:0])))
    else $error("interrupt output disagrees with enabled status");

  a_select_freezes_seq: assert property (@(posedge CLK) disable iff (SYS_RST)
    (APB_REQ.psel && !cfg_wr) |=> (state_q == $past(state_q)) && (idx_q == $past(idx_q)))
    else $error("sequencer moved while selected");

  a_watch_no_push: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_q == S_CONV && cur_ins[`INS_MODE_HI:`INS_MODE_LO] == M_WATCH) |-> !fifo_push)
    else $error("watchdog instruction wrote the FIFO");

  a_limit_fault_flag: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_q == S_CONV && res_pend_q && !APB_REQ.psel && !stby_q && (f1 || f2)
     && cur_ins[`INS_MODE_HI:`INS_MODE_LO] == M_WATCH) |=> stat_q[`ST_LIMIT])
    else $error("limit fault not flagged");

  a_wptr_wrap_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
    (fifo_push && wptr_q == 5'h1F) |=> (wptr_q == 5'h00))
    else $error("write pointer did not wrap to zero");

  a_rptr_read_only: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!fifo_pop && !dev_rst) |=> $stable(rptr_q))
    else $error("read pointer moved without a read");

  a_start_bit_runs: assert property (@(posedge CLK) disable iff (SYS_RST)
    (cfg_wr && APB_REQ.pwdata[`CFG_START] && !dev_rst) |=> run_q ##1 (state_q != S_CAL || $past(state_q) == S_CAL || $past(state_q) == S_IDLE))
    else $error("start bit did not start sequencer");

  a_full_stops_run: assert property (@(posedge CLK) disable iff (SYS_RST)
    (fifo_push && cnt_q == 6'h1F) |=> !run_q && stat_q[`ST_FULL])
    else $error("full FIFO did not stop sequencer");

  a_status_clear_read: assert property (@(posedge CLK) disable iff (SYS_RST)
    (stat_rd && stat_set == 8'h00) |=> ((stat_q & $past(rsp_q.prdata[7:0])) == 8'h00))
    else $error("status bits survived their read");

endmodule : das_seq_ctrl

// file: verilog/das_seq_regs.svh
// Purpose: Offsets, field positions, reset values and counts for the sequencer control block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only; included by bare name.
//
// What this block does
// - Three modes: 12-bit, 8-bit conversion, watchdog compare
// - Watchdog compares limits, never writes a result
// - Out-of-limit sample raises limit fault
// - Eight interrupt sources, each individually maskable
// - Chip select access suspends internal sequencing
// - Eight 48-bit words, three 16-bit sections
// - 2-bit section pointer selects RAM section
// - Start at 0, then loop or pause
// - Repeat until stopped, FIFO full, or count
// - Result FIFO of 32 16-bit entries
// - FIFO read-only through one address
// - Pointers advance and wrap 31 to 0
// - Write and read pointers are independent
// - Config write: start, reset, standby, calibrate, section
// - Programmable FIFO count raises data ready
// - Programmable instruction number raises interrupt before it
// - Status bits set regardless of enable
// - Status registers clear on read or reset
// - 16-bit timer delays selected instructions
// - Each limit section is high or low
// - Start bit one starts, zero stops
`ifndef DAS_SEQ_REGS_SVH
`define DAS_SEQ_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CFG_ADDR 8'h00
`define INTEN_ADDR 8'h04
`define INTST_ADDR 8'h08
`define TIMER_ADDR 8'h0C
`define FIFO_ADDR 8'h10
`define LIMST_ADDR 8'h14
`define RAM_BASE 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_START 0
`define CFG_RESET 1
`define CFG_STBY 2
`define CFG_CALFULL 3
`define CFG_CALOFS 4
`define CFG_PTR_LO 5
`define CFG_PTR_HI 6
`define CFG_CNTSTOP 7
`define INS_LOOP 0
`define INS_PAUSE 1
`define INS_DELAY 2
`define INS_MODE_LO 3
`define INS_MODE_HI 4
`define INS_CHAN_LO 5
`define INS_CHAN_HI 7
`define LIM_VAL_HI 8
`define LIM_HIGH 9
`define IE_INSTR_LO 8
`define IE_INSTR_HI 10
`define IE_COUNT_LO 11
`define IE_COUNT_HI 16
`define ST_LIMIT 0
`define ST_INSTR 1
`define ST_DRDY 2
`define ST_PAUSE 3
`define ST_FULL 4
`define ST_CAL 5
`define ST_STBY 6
`define ST_CYCLE 7

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define INTEN_RST 17'h00000
`define TIMER_RST 16'h0000
`define FIFO_DEPTH 6'h20
`define LAST_INSTR 3'h7

`endif

// file: verilog/das_seq_pkg.sv
// Purpose: Types shared by the sequencer control block and its bench.
// Assumes: APB with 8-bit byte address and 32-bit data.
// Notes: Offsets and fields live in das_seq_regs.svh.
package das_seq_pkg;

  // ----------------------------------------
  // Bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // ----------------------------------------
  // Converter request and modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    M_CONV12 = 2'b00,
    M_CONV8 = 2'b01,
    M_WATCH = 2'b10
  } conv_mode_t;

  typedef struct packed {
    logic start;
    logic [1:0] mode;
    logic [2:0] chan;
  } conv_req_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_PREP = 5'b00010,
    S_DELAY = 5'b00100,
    S_CONV = 5'b01000,
    S_CAL = 5'b10000
  } seq_state_t;

endpackage : das_seq_pkg

// file: verif/das_conv_model.sv
// Purpose: Converter and calibration stand-in behind the sequencer.
// Assumes: One result per start, lat+1 cycles after the edge that samples the start.
// Notes: Result bus toggles while no result is valid.
`timescale 1ns/1ps
module das_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire das_seq_pkg::conv_req_t req,
  input wire logic cal_start,
  input wire logic [15:0] sample,
  input wire logic [3:0] lat,
  output logic done,
  output logic [15:0] result,
  output logic cal_done
);
  import das_seq_pkg::*;
  int cnt;
  int ccnt;
  logic [15:0] held;

  // ------
  // One answer per start, never one unasked
  // ------
  always @(posedge clk) begin
    done <= 1'b0;
    cal_done <= 1'b0;
    result <= ~result; // Stale data must not look valid
    if (cnt == 1) begin
      done <= 1'b1;
      result <= held;
    end
    if (ccnt == 1) cal_done <= 1'b1;
    if (cnt > 0) cnt <= cnt - 1;
    if (ccnt > 0) ccnt <= ccnt - 1;
    if (req.start) begin
      cnt <= int'(lat) + 1;
      held <= sample;
    end
    if (cal_start) ccnt <= 25;
    if (rst) begin
      cnt <= 0;
      ccnt <= 0;
      result <= 16'h5A5A;
    end
  end
endmodule : das_conv_model

// file: verif/tb.sv
// Purpose: Self-checking bench for the sequencer control block.
// Assumes: Converter model answers every start.
// Notes: Polls leave idle gaps, since a selected bus freezes the sequencer.
`timescale 1ns/1ps
`include "das_seq_regs.svh"
module tb;
  import das_seq_pkg::*;
  logic CLK = 0;
  logic SYS_RST = 1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  conv_req_t creq;
  logic done, cal_st, cal_done, cal_full, stby, irq, e, fix = 0;
  logic [15:0] res, t, smp = 16'h0;
  logic [3:0] lat = 4'h3;
  logic [1:0] last_mode;
  logic [15:0] q[$];
  logic [31:0] v;
  logic [31:0] exp_ram [3][8];
  int miscompares = 0;
  int compares = 0;
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (x)); end end

  always #2 CLK = ~CLK;

  das_seq_ctrl u_das_seq_ctrl (.CLK(CLK), .SYS_RST(SYS_RST), .APB_REQ(req), .APB_RSP(rsp), .CONV_DONE(done),
    .CONV_RESULT(res), .CAL_DONE(cal_done), .CONV_REQ(creq), .CAL_START(cal_st), .CAL_FULL(cal_full),
    .STANDBY(stby), .INT_OUT(irq));
  das_conv_model u_das_conv_model (.clk(CLK), .rst(SYS_RST), .req(creq), .cal_start(cal_st), .sample(smp),
    .lat(lat), .done(done), .result(res), .cal_done(cal_done));

  // Fresh sample and latency each cycle; fixed sample for limit runs
  always @(posedge CLK) begin
    smp <= fix ? 16'h0032 : 16'($urandom);
    lat <= 4'($urandom_range(1, 9));
  end

  // Record the mode of each start and every result of a non-watchdog start
  always @(posedge CLK) begin
    if (creq.start) last_mode <= creq.mode;
    if (done && last_mode != M_WATCH) q.push_back(res);
  end

  // ------
  // Bus tasks
  // ------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // Launch only right after a rising edge
    @(posedge CLK);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge CLK);
    req.penable <= 1'b1;
    // Hold until pready is seen high at a rising edge
    do begin
      @(posedge CLK);
      n++;
    end while (rsp.pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    v = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask : apb

  // Only called while stopped
  task automatic ram(input logic [1:0] s, input int n, input logic [31:0] d);
    apb(1'b1, `CFG_ADDR, 32'(s) << 5);
    apb(1'b1, 8'(`RAM_BASE + 4 * n), d);
  endtask : ram

  // Poll the run bit with gaps between polls
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      repeat (8) @(posedge CLK);
      apb(1'b0, `CFG_ADDR, 32'h0);
      n++;
    end while (v[0] !== 1'b0 && n < 300);
    if (n >= 300) miscompares++;
  endtask : wait_idle

  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // ------
  // Tests
  // ------
  initial begin
    void'($urandom(28));
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    apb(1'b0, `CFG_ADDR, 32'h0);
    `CHK(v, 32'h0)
    apb(1'b0, `INTEN_ADDR, 32'h0);
    `CHK(v, 32'(`INTEN_RST))
    t = 16'($urandom_range(5, 40));
    apb(1'b1, `TIMER_ADDR, {16'h0, t});
    apb(1'b0, `TIMER_ADDR, 32'h0);
    `CHK(v, {16'h0, t})
    apb(1'b1, `FIFO_ADDR, 32'h1234);
    apb(1'b0, `FIFO_ADDR, 32'h0);
    `CHK(v, 32'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(e, 1'b1)
    $display("test map done");
    for (int s = 0; s < 3; s++) begin
      for (int n = 0; n < 8; n++) begin
        exp_ram[s][n] = 32'($urandom) & ((s == 0) ? 32'hFF : 32'h3FF);
        ram(2'(s), n, exp_ram[s][n]);
      end
    end
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `CFG_ADDR, 32'(s) << 5);
      for (int n = 0; n < 8; n++) begin
        apb(1'b0, 8'(`RAM_BASE + 4 * n), 32'h0);
        `CHK(v, exp_ram[s][n])
      end
    end
    $display("test ram done");
    // One paused instruction per mode; limit run has its enables masked
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, `CFG_ADDR, 32'h2);
      q.delete();
      fix <= (m == 2);
      ram(2'h0, 0, 32'hA2 | (32'(m) << 3) | ((m == 1) ? 32'h4 : 32'h0));
      ram(2'h1, 0, 32'h20A); // High limit +10
      ram(2'h2, 0, 32'h1F0); // Low limit -16
      apb(1'b1, `INTEN_ADDR, {15'h0, 6'h1, 3'h0, (m == 2) ? 8'h00 : 8'hFF});
      apb(1'b1, `CFG_ADDR, 32'h1);
      wait_idle();
      @(negedge CLK);
      `CHK(last_mode, 2'(m))
      `CHK(creq.chan, 3'h5)
      `CHK(irq, (m != 2))
      apb(1'b0, `FIFO_ADDR, 32'h0);
      t = (m == 2) ? 16'h0 : q.pop_front();
      `CHK(v[15:0], t)
      apb(1'b0, `INTST_ADDR, 32'h0);
      `CHK(v[3:0], (m == 2) ? 4'hB : 4'hE)
      @(negedge CLK);
      `CHK(irq, 1'b0)
      apb(1'b0, `INTST_ADDR, 32'h0);
      `CHK(v[3:0], 4'h0)
      apb(1'b0, `LIMST_ADDR, 32'h0);
      `CHK(v[15:0], (m == 2) ? 16'h0001 : 16'h0)
      $display("test mode %0d done", m);
    end
    // Looping run stops on a full FIFO; drain past empty
    fix <= 1'b0;
    apb(1'b1, `CFG_ADDR, 32'h2);
    q.delete();
    ram(2'h0, 0, 32'h1);
    apb(1'b1, `INTEN_ADDR, 32'h0);
    apb(1'b1, `CFG_ADDR, 32'h1);
    wait_idle();
    apb(1'b0, `INTST_ADDR, 32'h0);
    `CHK(v[4], 1'b1)
    for (int i = 0; i < 33; i++) begin
      apb(1'b0, `FIFO_ADDR, 32'h0);
      t = (i < 32) ? q[i] : 16'h0;
      `CHK(v[15:0], t)
    end
    $display("test fifo done");
    apb(1'b1, `CFG_ADDR, 32'h8);
    @(negedge CLK);
    `CHK(cal_full, 1'b1)
    for (int n = 0; n < 30 && v[5] !== 1'b1; n++) apb(1'b0, `INTST_ADDR, 32'h0);
    `CHK(v[5], 1'b1)
    apb(1'b1, `CFG_ADDR, 32'h2);
    apb(1'b1, `CFG_ADDR, 32'h4);
    @(negedge CLK);
    `CHK(stby, 1'b1)
    $display("test cal done");
    wrap_up();
  end

  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule : tb
